// >>> epw_pkg.sv
// constants, state encodings and carrier structs of the external peripheral window bridge
// assumes a single processor clock domain; no module of its own lives here
package epw_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // address window and transfer limits
  localparam logic [31:0] WIN_BASE   = 32'he0040000; // first byte of the window
  localparam logic [31:0] WIN_LAST   = 32'he00fffff; // last byte of the window
  localparam int          PADDR_W    = 20;           // address bits that decode the window
  localparam logic [1:0]  SIZE_WORD  = 2'h2;         // size code of a 32-bit access
  localparam logic [1:0]  ALIGN_WORD = 2'h0;         // low address bits of an aligned word
  localparam logic [31:0] DATA_ZERO  = 32'h00000000; // read data of a refused or write access

  ////////////////////////////////////////////////////////////////////////////////
  // bridge sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00, // waiting for a request
    ST_SETUP  = 2'b01, // apb setup phase
    ST_ACCESS = 2'b10, // apb access phase, waiting on pready
    ST_DONE   = 2'b11  // answer shown to the requester for one cycle
  } br_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [31:0] addr;      // full byte address
    logic [31:0] wdata;     // write word, register value
    logic        write;     // 1 write, 0 read
    logic [1:0]  size;      // 0 byte, 1 halfword, 2 word
    logic        src_local; // 1 when issued by the local core
  } req_t;

  typedef struct packed {
    logic [31:0] rdata;     // read word
    logic        err;       // access refused or slave error
  } rsp_t;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic handler;    // 1 handler mode, 0 thread mode
    logic privileged; // current code is privileged
  } mode_state_t;

endpackage

// >>> epw_mode_tracker.sv
// thread / handler mode state and the privilege level that the window checks
// assumes exception entry and return arrive as one-cycle pulses on pclk
`timescale 1ns/10ps
module epw_mode_tracker (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic exc_take,      // exception taken, one-cycle pulse
  input  wire logic exc_return,    // exception return, one-cycle pulse
  input  wire logic thread_unpriv, // thread code runs unprivileged
  output logic      handler_mode,  // registered mode
  output logic      privileged     // registered privilege
);

  epw_pkg::mode_state_t m_q; // all state
  epw_pkg::mode_state_t m_d; // next state

  ////////////////////////////////////////////////////////////////////////////////
  // next mode; a take in the same cycle as a return wins (tail chain)
  always_comb begin
    m_d = m_q;
    if (exc_take) begin
      m_d.handler = 1'b1; // [R12]
    end else if (exc_return) begin
      m_d.handler = 1'b0; // [R11]
    end
    // handler code is always privileged, thread code follows its control bit
    m_d.privileged = m_d.handler | ~thread_unpriv; // [R11] [R12]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; reset lands in privileged thread mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_q.handler    <= 1'b0; // [R11]
      m_q.privileged <= 1'b1;
    end else if (clk_en) begin
      m_q <= m_d;
    end
  end

  assign handler_mode = m_q.handler;
  assign privileged   = m_q.privileged;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  a_handler_privileged: assert property (handler_mode |-> privileged) // [R12]
    else $error("handler mode seen unprivileged");
  a_take_to_handler: assert property (exc_take |=> handler_mode) // [R12]
    else $error("exception taken without entering handler mode");
  a_return_to_thread: assert property (exc_return && !exc_take |=> !handler_mode) // [R11]
    else $error("exception return did not reach thread mode");

endmodule

// >>> external_peripheral_apb_port.sv
// apb master port of the external peripheral window, core and debug requesters
// assumes requesters hold a request until its done pulse and drop it at that edge
//
// What this block does
// [R1] window accesses from core and debug go to apb
// [R2] core wins over debug, debug waits
// [R3] only window decode address bits reach apb
// [R4] unprivileged accesses never reach the peripherals
// [R5] words pass unchanged, little-endian, no swapping
// [R6] one transfer at a time, no buffering
// [R7] requesters never issue unaligned window accesses
// [R8] only word accesses are carried
// [R9] only local core and debug port admitted
// [R10] agent sets global trace enable before trace
// [R11] reset and exception return enter thread mode
// [R12] exceptions enter handler mode, always privileged
// [R13] refused accesses answer error, no bus transfer
`timescale 1ns/10ps
module external_peripheral_apb_port (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,         // freezes all state while low
  // core data requester
  input  wire logic              core_req_valid, // level, held until core_done
  input  wire epw_pkg::req_t     core_req,
  output logic                   core_done,      // one-cycle answer pulse
  // debug access port requester
  input  wire logic              dbg_req_valid,  // level, held until dbg_done
  input  wire epw_pkg::req_t     dbg_req,
  output logic                   dbg_done,       // one-cycle answer pulse
  // answer shared by both requesters, valid with either done
  output epw_pkg::rsp_t          rsp,
  // mode events from the exception logic
  input  wire logic              exc_take,
  input  wire logic              exc_return,
  input  wire logic              thread_unpriv,
  output logic                   handler_mode,
  // apb master
  output epw_pkg::apb_req_t      apb_out,
  input  wire epw_pkg::apb_rsp_t apb_in
);

  ////////////////////////////////////////////////////////////////////////////////
  // state of the bridge as one record
  typedef struct packed {
    epw_pkg::br_state_t state;     // sequencer state
    logic               owner_dbg; // transfer in flight belongs to debug
    logic               core_done; // answer pulse to the core
    logic               dbg_done;  // answer pulse to debug
    epw_pkg::rsp_t      rsp;       // latched answer
    epw_pkg::apb_req_t  apb;       // apb request signals
  } bridge_state_t;

  bridge_state_t s_q;    // registered state
  bridge_state_t s_d;    // next state
  logic core_priv;       // privilege of the core right now
  logic core_in_win;     // core address inside the window
  logic dbg_in_win;      // debug address inside the window
  logic core_ok;         // core request passes every limit
  logic dbg_ok;          // debug request passes every limit

  ////////////////////////////////////////////////////////////////////////////////
  // mode tracker supplies the core privilege level
  epw_mode_tracker u_mode (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .exc_take      (exc_take),
    .exc_return    (exc_return),
    .thread_unpriv (thread_unpriv),
    .handler_mode  (handler_mode),
    .privileged    (core_priv)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // window decode and access limits
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a >= epw_pkg::WIN_BASE) && (a <= epw_pkg::WIN_LAST); // [R1]
  endfunction

  // word size and word alignment; an unaligned request is refused outright
  function automatic logic word_shape(input epw_pkg::req_t r);
    word_shape = (r.size == epw_pkg::SIZE_WORD)        // [R8]
               && (r.addr[1:0] == epw_pkg::ALIGN_WORD); // [R7]
  endfunction

  always_comb begin
    core_in_win = in_window(core_req.addr);
    dbg_in_win  = in_window(dbg_req.addr);
    // core must be privileged and be the local processor
    core_ok = core_in_win && word_shape(core_req)
            && core_priv           // [R4]
            && core_req.src_local; // [R9]
    // the debug port is always privileged and admitted whatever its source flag
    dbg_ok  = dbg_in_win && word_shape(dbg_req); // [R9]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: pick, setup, access, answer
  always_comb begin
    s_d           = s_q;
    s_d.core_done = 1'b0;
    s_d.dbg_done  = 1'b0;
    case (s_q.state)
      epw_pkg::ST_IDLE: begin
        // core is looked at first; debug only when the core is quiet
        if (core_req_valid) begin // [R2]
          s_d.owner_dbg = 1'b0;
          if (core_ok) begin
            s_d.state       = epw_pkg::ST_SETUP;
            s_d.apb.psel    = 1'b1; // [R1]
            s_d.apb.pwrite  = core_req.write;
            // only the decode bits of the window go out
            s_d.apb.paddr   = core_req.addr[epw_pkg::PADDR_W-1:0]; // [R3]
            // the word is the register value; no lane swap whatever the core endianness
            s_d.apb.pwdata  = core_req.wdata; // [R5]
          end else begin
            // refused: answer at once with an error, bus left alone
            s_d.state       = epw_pkg::ST_DONE; // [R13]
            s_d.core_done   = 1'b1;
            s_d.rsp.err     = 1'b1;
            s_d.rsp.rdata   = epw_pkg::DATA_ZERO;
          end
        end else if (dbg_req_valid) begin
          s_d.owner_dbg = 1'b1;
          if (dbg_ok) begin
            s_d.state       = epw_pkg::ST_SETUP;
            s_d.apb.psel    = 1'b1; // [R1]
            s_d.apb.pwrite  = dbg_req.write;
            s_d.apb.paddr   = dbg_req.addr[epw_pkg::PADDR_W-1:0]; // [R3]
            s_d.apb.pwdata  = dbg_req.wdata; // [R5]
          end else begin
            s_d.state       = epw_pkg::ST_DONE; // [R13]
            s_d.dbg_done    = 1'b1;
            s_d.rsp.err     = 1'b1;
            s_d.rsp.rdata   = epw_pkg::DATA_ZERO;
          end
        end
      end
      epw_pkg::ST_SETUP: begin
        // setup lasts exactly one cycle
        s_d.state       = epw_pkg::ST_ACCESS;
        s_d.apb.penable = 1'b1;
      end
      epw_pkg::ST_ACCESS: begin
        // hold everything until the slave is ready
        if (apb_in.pready) begin
          s_d.state       = epw_pkg::ST_DONE;
          s_d.apb.psel    = 1'b0;
          s_d.apb.penable = 1'b0;
          s_d.rsp.err     = apb_in.pslverr;
          // read data passes in bus byte order, untouched
          s_d.rsp.rdata   = s_q.apb.pwrite ? epw_pkg::DATA_ZERO : apb_in.prdata; // [R5]
          s_d.core_done   = ~s_q.owner_dbg;
          s_d.dbg_done    = s_q.owner_dbg;
        end
      end
      epw_pkg::ST_DONE: begin
        // one idle cycle lets the requester drop its request; nothing is queued
        s_d.state = epw_pkg::ST_IDLE; // [R6]
      end
      default: begin
        s_d.state = epw_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register, frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.state       <= epw_pkg::ST_IDLE;
      s_q.owner_dbg   <= 1'b0;
      s_q.core_done   <= 1'b0;
      s_q.dbg_done    <= 1'b0;
      s_q.rsp.rdata   <= epw_pkg::DATA_ZERO;
      s_q.rsp.err     <= 1'b0;
      s_q.apb.psel    <= 1'b0;
      s_q.apb.penable <= 1'b0;
      s_q.apb.pwrite  <= 1'b0;
      s_q.apb.paddr   <= '0;
      s_q.apb.pwdata  <= epw_pkg::DATA_ZERO;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state record
  assign core_done = s_q.core_done;
  assign dbg_done  = s_q.dbg_done;
  assign rsp       = s_q.rsp;
  assign apb_out   = s_q.apb;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  // core request seen in idle
  sequence seq_core_pick;
    s_q.state == epw_pkg::ST_IDLE && core_req_valid;
  endsequence

  // debug request seen in idle with the core quiet
  sequence seq_dbg_pick;
    s_q.state == epw_pkg::ST_IDLE && !core_req_valid && dbg_req_valid;
  endsequence

  // apb transfer finishing
  sequence seq_apb_end;
    apb_out.psel && apb_out.penable && apb_in.pready;
  endsequence

  // refused request: no select, error answer to the core
  sequence seq_core_refused;
    !apb_out.psel && core_done && rsp.err;
  endsequence

  a_good_core_issued: assert property (seq_core_pick and core_ok |=> // [R1]
      apb_out.psel && !apb_out.penable ##1 apb_out.psel && apb_out.penable)
    else $error("accepted core access did not run setup then access");
  a_core_before_dbg: assert property (seq_core_pick and dbg_req_valid |=> // [R2]
      !s_q.owner_dbg && !dbg_done)
    else $error("debug served ahead of a pending core access");
  a_addr_decode_bits: assert property (seq_core_pick and core_ok |=> // [R3]
      apb_out.paddr == $past(core_req.addr[epw_pkg::PADDR_W-1:0]))
    else $error("apb address not the window decode bits");
  a_unpriv_refused: assert property (seq_core_pick and !core_priv |=> // [R4]
      seq_core_refused ##1 !apb_out.psel)
    else $error("unprivileged access reached the bus");
  a_wdata_unswapped: assert property (seq_dbg_pick and dbg_ok |=> // [R5]
      apb_out.pwdata == $past(dbg_req.wdata))
    else $error("write word changed on its way to the bus");
  a_one_at_time: assert property (seq_apb_end |=> !apb_out.psel [*2]) // [R6]
    else $error("new transfer started before the answer cycle passed");
  a_word_only: assert property (seq_core_pick and core_req.size != epw_pkg::SIZE_WORD |=> // [R8]
      seq_core_refused)
    else $error("non-word access not refused");
  a_foreign_refused: assert property (seq_core_pick and !core_req.src_local |=> // [R9]
      seq_core_refused)
    else $error("access from another processor not refused");
  a_refused_no_bus: assert property (seq_dbg_pick and !dbg_ok |=> // [R13]
      dbg_done && rsp.err && !apb_out.psel)
    else $error("refused debug access not answered with error");
  a_read_data_back: assert property (seq_apb_end and !apb_out.pwrite |=> // [R5]
      rsp.rdata == $past(apb_in.prdata) && (core_done || dbg_done))
    else $error("read word not returned with the answer");

  ////////////////////////////////////////////////////////////////////////////////
  // more checks: debug path, bus phases, answer pulses

  // setup cycle, then one access cycle
  sequence seq_setup_access;
    apb_out.psel && !apb_out.penable ##1 apb_out.psel && apb_out.penable;
  endsequence

  // access cycle, slave not yet ready
  sequence seq_apb_wait;
    apb_out.psel && apb_out.penable && !apb_in.pready;
  endsequence

  // accepted debug access runs both phases
  a_good_dbg_issued: assert property (seq_dbg_pick and dbg_ok |=> // [R1]
      seq_setup_access)
    else $error("accepted debug access did not run setup then access");

  // core address outside the window is refused
  a_core_outside_refused: assert property (seq_core_pick and !core_in_win |=> // [R1]
      seq_core_refused)
    else $error("core access outside the window not refused");

  // debug address outside the window is refused
  a_dbg_outside_refused: assert property (seq_dbg_pick and !dbg_in_win |=> // [R1]
      dbg_done && rsp.err && !apb_out.psel)
    else $error("debug access outside the window not refused");

  // no debug answer while the core owns the bridge
  a_dbg_held_back: assert property (s_q.state != epw_pkg::ST_IDLE && !s_q.owner_dbg |-> // [R2]
      !dbg_done)
    else $error("debug answered while the core owned the bridge");

  // debug address bits are the window decode bits
  a_dbg_decode_bits: assert property (seq_dbg_pick and dbg_ok |=> // [R3]
      apb_out.paddr == $past(dbg_req.addr[epw_pkg::PADDR_W-1:0]))
    else $error("debug apb address not the window decode bits");

  // core write word goes out unchanged
  a_core_wdata_kept: assert property (seq_core_pick and core_ok |=> // [R5]
      apb_out.pwdata == $past(core_req.wdata))
    else $error("core write word changed on its way to the bus");

  // write answers carry a zero word
  a_write_answer_zero: assert property (seq_apb_end and apb_out.pwrite |=> // [R5]
      rsp.rdata == epw_pkg::DATA_ZERO)
    else $error("write answer carried a nonzero word");

  // setup lasts exactly one cycle
  a_setup_one_cycle: assert property (apb_out.psel && !apb_out.penable |=> // [R6]
      apb_out.psel && apb_out.penable)
    else $error("setup phase not followed by access phase");

  // request held unchanged while the slave waits
  a_access_held: assert property (seq_apb_wait |=> // [R6]
      apb_out.psel && apb_out.penable && $stable(apb_out.paddr)
      && $stable(apb_out.pwdata) && $stable(apb_out.pwrite))
    else $error("apb request changed during wait states");

  // answer pulses last one cycle
  a_answer_one_cycle: assert property (core_done || dbg_done |=> // [R6]
      !core_done && !dbg_done)
    else $error("answer pulse longer than one cycle");

  // a transfer starts only from idle
  a_start_from_idle: assert property ($rose(apb_out.psel) |-> // [R6]
      $past(s_q.state) == epw_pkg::ST_IDLE)
    else $error("transfer started outside idle");

  // debug sizes other than word are refused
  a_dbg_word_only: assert property (seq_dbg_pick and // [R8]
      dbg_req.size != epw_pkg::SIZE_WORD |=> dbg_done && rsp.err && !apb_out.psel)
    else $error("non-word debug access not refused");

  // debug port admitted whatever its source flag
  a_dbg_any_source: assert property (seq_dbg_pick and dbg_ok and !dbg_req.src_local |=> // [R9]
      apb_out.psel)
    else $error("debug access refused for its source");

  // handler code always passes the privilege check
  a_handler_admitted: assert property (handler_mode |-> // [R12]
      core_priv)
    else $error("handler mode code refused as unprivileged");

  // refused core access shows no select for two cycles
  a_refused_core_quiet: assert property (seq_core_pick and !core_ok |=> // [R13]
      !apb_out.psel [*2])
    else $error("refused core access reached the bus");

  // refused core access answers error with a zero word
  a_refused_error_zero: assert property (seq_core_pick and !core_ok |=> // [R13]
      core_done && rsp.err && rsp.rdata == epw_pkg::DATA_ZERO)
    else $error("refused core access not answered with error");

endmodule

// >>> epw_apb_slave_model.sv
// behavioural apb slave standing on the far side of the window bridge
// assumes one pclk domain; wait_cycles and err_en change only while the bus is idle
`timescale 1ns/10ps
module epw_apb_slave_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire epw_pkg::apb_req_t apb_out,
  input  wire logic [3:0]        wait_cycles, // access cycles before pready, beyond the first one
  input  wire logic              err_en,      // answer with pslverr
  output epw_pkg::apb_rsp_t      apb_in
);
  logic [31:0] mem [16]; // small word store, indexed by paddr[5:2]
  logic [3:0]  cnt;      // access cycles seen so far
  ////////////////////////////////////////////////////////////////////////////////
  // wait states, then one ready cycle; read data is junk while not ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= 4'h0;
      apb_in <= '0;
      mem    <= '{default: 32'h00000000};
    end else if (apb_out.psel && apb_out.penable && !apb_in.pready) begin
      cnt <= cnt + 4'h1;
      if (cnt >= wait_cycles) begin
        apb_in.pready  <= 1'b1;
        apb_in.pslverr <= err_en;
        apb_in.prdata  <= mem[apb_out.paddr[5:2]];
        if (apb_out.pwrite && !err_en) begin
          mem[apb_out.paddr[5:2]] <= apb_out.pwdata;
        end
      end else begin
        apb_in.prdata <= ~apb_in.prdata;
      end
    end else begin
      cnt            <= 4'h0;
      apb_in.pready  <= 1'b0;
      apb_in.pslverr <= 1'b0;
      apb_in.prdata  <= ~apb_in.prdata;
    end
  end
endmodule

// >>> external_peripheral_apb_port_test.sv
// self-checking bench of the window bridge: core and debug requesters, apb slave model
// assumes the design's internal assertions; expectations kept in queues, checked at negedge
`timescale 1ns/10ps
module external_peripheral_apb_port_test;
  typedef struct packed { logic dbg; epw_pkg::rsp_t rsp; } exp_t;
  typedef struct packed { logic w; logic [19:0] a; logic [31:0] d; } xfer_t;
  logic pclk = 0, presetn = 0, clk_en = 1, err_en = 0;
  logic core_req_valid = 0, dbg_req_valid = 0, core_done, dbg_done, handler_mode;
  logic exc_take = 0, exc_return = 0, thread_unpriv = 0, priv_exp = 1;
  logic [3:0] wait_cycles = 4'h0;
  epw_pkg::req_t core_req = '0, dbg_req = '0;
  epw_pkg::rsp_t rsp;
  epw_pkg::apb_req_t apb_out;
  epw_pkg::apb_rsp_t apb_in;
  exp_t q_rsp[$];
  xfer_t q_bus[$];
  logic [31:0] shadow [16] = '{default: 32'h00000000};
  logic [31:0] seed = 32'h0000002e;
  int mismatches = 0, total_checks = 0;
  external_peripheral_apb_port DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .core_req_valid(core_req_valid), .core_req(core_req), .core_done(core_done),
    .dbg_req_valid(dbg_req_valid), .dbg_req(dbg_req), .dbg_done(dbg_done), .rsp(rsp),
    .exc_take(exc_take), .exc_return(exc_return), .thread_unpriv(thread_unpriv),
    .handler_mode(handler_mode), .apb_out(apb_out), .apb_in(apb_in));
  epw_apb_slave_model slave (.pclk(pclk), .presetn(presetn), .apb_out(apb_out),
    .wait_cycles(wait_cycles), .err_en(err_en), .apb_in(apb_in));
  initial forever #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // work out the answer and any bus transfer from the window limits
  task automatic expect_acc(input logic dbg, input epw_pkg::req_t r);
    logic ok;
    epw_pkg::rsp_t e;
    ok = r.addr >= epw_pkg::WIN_BASE && r.addr <= epw_pkg::WIN_LAST && r.size == epw_pkg::SIZE_WORD
         && r.addr[1:0] == epw_pkg::ALIGN_WORD && (dbg || (r.src_local && priv_exp));
    e.err = ok ? err_en : 1'b1;
    e.rdata = (ok && !r.write) ? shadow[r.addr[5:2]] : epw_pkg::DATA_ZERO;
    if (ok) q_bus.push_back({r.write, r.addr[19:0], r.wdata});
    if (ok && r.write && !err_en) shadow[r.addr[5:2]] = r.wdata;
    q_rsp.push_back({dbg, e});
  endtask
  // hold one request until its done pulse, drop it at the edge that ends it
  task automatic run_req(input logic dbg, input epw_pkg::req_t r);
    int n;
    @(posedge pclk);
    if (dbg) begin dbg_req_valid <= 1'b1; dbg_req <= r; end
    else begin core_req_valid <= 1'b1; core_req <= r; end
    n = 0;
    do begin @(negedge pclk); n++; end while (!(dbg ? dbg_done : core_done) && n < 80);
    if (!(dbg ? dbg_done : core_done)) begin
      check(72'h1, 72'h0, "no answer");
      final_report();
    end
    @(posedge pclk);
    if (dbg) dbg_req_valid <= 1'b0;
    else core_req_valid <= 1'b0;
  endtask
  task automatic acc(input logic dbg, input logic [31:0] a, input logic w,
                     input logic [1:0] sz, input logic loc);
    epw_pkg::req_t r;
    r = '{addr: a, wdata: xs(), write: w, size: sz, src_local: loc};
    expect_acc(dbg, r);
    run_req(dbg, r);
  endtask
  task automatic mode_pulse(input logic take);
    @(posedge pclk) begin exc_take <= take; exc_return <= !take; end
    @(posedge pclk) begin exc_take <= 1'b0; exc_return <= 1'b0; end
    repeat (2) @(posedge pclk);
    @(negedge pclk) check(72'(handler_mode), 72'(take), "mode");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: answers and completed bus transfers against the oldest note
  always @(negedge pclk) begin
    exp_t e;
    xfer_t b;
    if (presetn && (core_done || dbg_done)) begin
      if (q_rsp.size() == 0) check(72'h1, 72'h0, "unasked answer");
      else begin
        e = q_rsp.pop_front();
        check({core_done, dbg_done, rsp}, {!e.dbg, e.dbg, e.rsp}, "answer");
      end
    end
    if (presetn && apb_out.psel && apb_out.penable && apb_in.pready) begin
      if (q_bus.size() == 0) check(72'h1, 72'h0, "unasked bus transfer");
      else begin
        b = q_bus.pop_front();
        check({apb_out.pwrite, apb_out.paddr, apb_out.pwdata}, b, "bus transfer");
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] bad [4];
    epw_pkg::req_t r1, r2;
    bad = '{32'he00ffffc, 32'he003fffc, 32'he0100000, 32'he0040002};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk) check({apb_out.psel, handler_mode}, 72'h0, "reset state");
    // freeze: a take seen while clk_en is low must leave the mode alone
    @(posedge pclk) begin clk_en <= 1'b0; exc_take <= 1'b1; end
    @(posedge pclk) exc_take <= 1'b0;
    @(posedge pclk) clk_en <= 1'b1;
    @(negedge pclk) check(72'(handler_mode), 72'h0, "frozen mode");
    // no trace is enabled here, so no global trace enable write is due
    for (int i = 0; i < 6; i++) begin
      wait_cycles = 4'(xs() % 4);
      acc(i[0], epw_pkg::WIN_BASE + 32'(i * 4), 1'b1, epw_pkg::SIZE_WORD, 1'b1);
      acc(!i[0], epw_pkg::WIN_BASE + 32'(i * 4), 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    end
    for (int i = 0; i < 4; i++) acc(i[0], bad[i], 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    for (int i = 0; i < 4; i++) acc(i[0], epw_pkg::WIN_BASE, 1'b1, 2'(i), 1'b1);
    acc(1'b0, epw_pkg::WIN_BASE, 1'b1, epw_pkg::SIZE_WORD, 1'b0);
    acc(1'b1, epw_pkg::WIN_BASE, 1'b0, epw_pkg::SIZE_WORD, 1'b0);
    err_en = 1'b1;
    acc(1'b0, epw_pkg::WIN_BASE + 32'h8, 1'b1, epw_pkg::SIZE_WORD, 1'b1);
    acc(1'b0, epw_pkg::WIN_BASE + 32'h8, 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    err_en = 1'b0;
    @(posedge pclk) thread_unpriv <= 1'b1;
    repeat (2) @(posedge pclk);
    priv_exp = 1'b0;
    acc(1'b0, epw_pkg::WIN_BASE, 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    acc(1'b1, epw_pkg::WIN_BASE, 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    mode_pulse(1'b1);
    priv_exp = 1'b1;
    acc(1'b0, epw_pkg::WIN_BASE, 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    mode_pulse(1'b0);
    priv_exp = 1'b0;
    acc(1'b0, epw_pkg::WIN_BASE, 1'b0, epw_pkg::SIZE_WORD, 1'b1);
    @(posedge pclk) thread_unpriv <= 1'b0;
    repeat (2) @(posedge pclk);
    priv_exp = 1'b1;
    wait_cycles = 4'h3;
    for (int i = 0; i < 2; i++) begin
      r1 = '{addr: epw_pkg::WIN_BASE + 32'h20, wdata: xs(), write: 1'b1, size: 2'h2, src_local: 1'b1};
      r2 = '{addr: epw_pkg::WIN_BASE + 32'h20, wdata: xs(), write: i[0], size: 2'h2, src_local: 1'b1};
      expect_acc(1'b0, r1);
      expect_acc(1'b1, r2);
      fork
        run_req(1'b0, r1);
        run_req(1'b1, r2);
      join
    end
    repeat (4) @(posedge pclk);
    check(72'(q_rsp.size() + q_bus.size()), 72'h0, "notes left over");
    final_report();
  end
endmodule
